//--- bmrm_defs.svh
// Purpose: Constants for the battery monitor register map
// Assumes: 250 MHz system clock
// Notes:   Offsets are byte addresses in the 256-byte space
`ifndef BMRM_DEFS_SVH
`define BMRM_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define BMRM_PROTECTION_CONTROL  8'h00
`define BMRM_DEVICE_STATUS       8'h01
`define BMRM_NONVOLATILE_CONTROL 8'h07
`define BMRM_SPECIAL_FEATURE     8'h08
`define BMRM_VOLTAGE_HIGH_BYTE   8'h0c
`define BMRM_VOLTAGE_LOW_BYTE    8'h0d
`define BMRM_CURRENT_HIGH_BYTE   8'h0e
`define BMRM_CURRENT_LOW_BYTE    8'h0f
`define BMRM_CHARGE_TOTAL_HIGH   8'h10
`define BMRM_CHARGE_TOTAL_LOW    8'h11
`define BMRM_TEMPERATURE_HIGH    8'h18
`define BMRM_TEMPERATURE_LOW     8'h19

// ----------------------------------------
// Memory regions (upper nibble of address), block 1 default indices (lower nibble)
// ----------------------------------------
`define BMRM_NV_BLOCK0_BASE      4'h2
`define BMRM_NV_BLOCK1_BASE      4'h3
`define BMRM_SRAM_BASE           4'h8
`define BMRM_DEFAULT_PROT_INDEX  4'h0
`define BMRM_DEFAULT_STAT_INDEX  4'h1

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BMRM_PROT_OVER_VOLT_BIT  7
`define BMRM_PROT_UNDER_VOLT_BIT 6
`define BMRM_PROT_CHG_OC_BIT     5
`define BMRM_PROT_DIS_OC_BIT     4
`define BMRM_PROT_CHG_PIN_BIT    3
`define BMRM_PROT_DIS_PIN_BIT    2
`define BMRM_PROT_CHG_EN_BIT     1
`define BMRM_PROT_DIS_EN_BIT     0
`define BMRM_STATUS_MASK         8'h38
`define BMRM_STATUS_SLEEP_BIT    5
`define BMRM_NVC_COPY_BIT        7
`define BMRM_NVC_LOCK_EN_BIT     6
`define BMRM_SF_SWITCH_BIT       7
`define BMRM_SF_GPIO_BIT         6

// ----------------------------------------
// Reset values
// ----------------------------------------
`define BMRM_STATUS_RESET        8'h00
`define BMRM_ENABLE_RESET        1'b1

// ----------------------------------------
// Timing
// ----------------------------------------
`define BMRM_CLOCK_MHZ           250
`define BMRM_TEMP_PERIOD_MS      220
`define BMRM_TEMP_CYCLES         (`BMRM_TEMP_PERIOD_MS * 1000 * `BMRM_CLOCK_MHZ)
`define BMRM_DATA_LOW_MS         2000
`define BMRM_DATA_LOW_CYCLES     (`BMRM_DATA_LOW_MS * 1000 * `BMRM_CLOCK_MHZ)
`define BMRM_COPY_CYCLES         16'h0010

`endif

//--- bmrm_pkg.sv
// Purpose: Types for the battery monitor register map
// Assumes: Nothing beyond the defs header
// Notes:   Commands arrive already decoded from the serial link
package bmrm_pkg;

  // ----------------------------------------
  // Memory commands
  // ----------------------------------------
  typedef enum logic [2:0]
  {
    BMRM_CMD_NONE   = 3'h0,
    BMRM_CMD_COPY   = 3'h1,
    BMRM_CMD_RECALL = 3'h2,
    BMRM_CMD_LOCK   = 3'h3
  } bmrm_cmd_e;

  // ----------------------------------------
  // Power modes
  // ----------------------------------------
  typedef enum logic
  {
    BMRM_ACTIVE = 1'b0,
    BMRM_SLEEP  = 1'b1
  } bmrm_mode_e;

endpackage

//--- bmrm_register_map.sv
// Purpose: Register and memory map of a battery monitor
// Assumes: Link decoder hands over byte reads, writes and memory commands
// Notes:   Nonvolatile store is modelled as flops; copy busy time is short
`include "bmrm_defs.svh"

// Notes on behaviour
// - Temperature register takes a new signed eighth-degree sample every 220 ms.
// - General I/O bit zero drives pin low, one releases; reads sense pin.
// - Sleep or long data-low releases I/O driver and forces bit to one.
// - Power-switch low during sleep wakes device and turns discharge path on.
// - Power-switch low while active only latches zero in the switch bit.
// - A 256-byte address space, registers in lowest 32 bytes.
// - Reading a high byte latches the pair until the read command ends.
// - Nonvolatile accesses hit shadow RAM; writes to locked blocks are dropped.
// - Copy stores shadow into nonvolatile only for unlocked blocks.
// - Recall reloads shadow from nonvolatile, locked or not.
// - Block 0 at 20h, block 1 at 30h, SRAM at 80h; rest reserved.
// - Blocks are writable until locked, then read-only until reset.
// - Protection flags set on their condition and stay until host clears.
// - Protection byte: four sticky flags, two pin mirrors, two enables.
// - Pin mirror bits are read-only and show the control outputs.
// - Charge enable zero forces charge control high; one allows charging.
// - Discharge enable zero forces discharge control high; one allows it.
// - Waking from sleep sets both enable bits.
// - Block 1 recall loads enables from the stored protection default.
// - Block 1 recall loads status bits from the stored status default.
// - Switch latch returns to one only on a host write of one.
// - With sleep enable, data low too long sleeps; data high wakes.
// - Control outputs are OR of conditions (charge skips discharge overcurrent, discharge skips overvoltage), cleared enable and sleep.
module bmrm_register_map
#(
  parameter int unsigned TEMP_CYCLES     = `BMRM_TEMP_CYCLES,
  parameter int unsigned DATA_LOW_CYCLES = `BMRM_DATA_LOW_CYCLES
)
(
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  // Byte access from the link decoder
  input  wire logic        rd_strobe_in,
  input  wire logic        wr_strobe_in,
  input  wire logic        rd_cmd_end_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [7:0]  wr_data_in,
  output logic      [7:0]  rd_data_out,
  // Memory commands
  input  wire logic        cmd_valid_in,
  input  wire bmrm_pkg::bmrm_cmd_e cmd_in,
  input  wire logic        cmd_block_in,
  // Measurement results
  input  wire logic        voltage_valid_in,
  input  wire logic [15:0] voltage_in,
  input  wire logic        current_valid_in,
  input  wire logic [15:0] current_in,
  input  wire logic        charge_total_valid_in,
  input  wire logic [15:0] charge_total_in,
  input  wire logic [15:0] temperature_in,
  // Protection conditions
  input  wire logic        over_voltage_in,
  input  wire logic        under_voltage_in,
  input  wire logic        charge_overcurrent_in,
  input  wire logic        discharge_overcurrent_in,
  // Pins
  input  wire logic        serial_data_in,
  input  wire logic        power_switch_n_in,
  input  wire logic        general_io_pin_in,
  output logic             general_io_pin_out,
  output logic             general_io_pin_oe_out,
  output logic             charge_control_n_out,
  output logic             discharge_control_n_out,
  // State
  output logic             sleep_out,
  output logic             copy_busy_out
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] data_sync;
  logic [2:0] switch_sync;
  logic [2:0] gpio_sync;
  logic       data_level;
  logic       switch_level;
  logic       gpio_level;

  // Level changes only when the second and third stage agree
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      data_sync   <= 3'h7;
      switch_sync <= 3'h7;
      gpio_sync   <= 3'h7;
      data_level  <= 1'b1;
      switch_level <= 1'b1;
      gpio_level  <= 1'b1;
    end
    else
    begin
      data_sync   <= {data_sync[1:0], serial_data_in};
      switch_sync <= {switch_sync[1:0], power_switch_n_in};
      gpio_sync   <= {gpio_sync[1:0], general_io_pin_in};
      if (data_sync[1] == data_sync[2])
        data_level <= data_sync[2];
      if (switch_sync[1] == switch_sync[2])
        switch_level <= switch_sync[2];
      if (gpio_sync[1] == gpio_sync[2])
        gpio_level <= gpio_sync[2];
    end
  end

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [3:0]  prot_flags;
  logic        charge_enable;
  logic        discharge_enable;
  logic [7:0]  status_bits;
  logic        lock_enable;
  logic [1:0]  block_locked;
  logic        switch_latch;
  logic        gpio_bit;
  logic [15:0] voltage_reg;
  logic [15:0] current_reg;
  logic [15:0] charge_total_reg;
  logic [15:0] temperature_reg;
  logic [7:0]  shadow [0:31];
  logic [7:0]  nonvol [0:31];
  logic [7:0]  sram [0:15];
  logic [7:0]  pair_low;
  logic        pair_held;
  logic [15:0] copy_count;
  logic        long_low;
  logic [31:0] low_count;
  logic [31:0] temp_count;
  bmrm_pkg::bmrm_mode_e mode;

  logic        wr_nv;
  logic        wr_sram;
  logic        nv_blk;
  logic        recall_b1;
  logic        copy_go;
  logic        wake;

  assign nv_blk  = addr_in[4];
  assign wr_nv   = wr_strobe_in && (addr_in[7:5] == 3'h1) && !block_locked[nv_blk] && (copy_count == 16'h0000);
  assign wr_sram = wr_strobe_in && (addr_in[7:4] == `BMRM_SRAM_BASE);
  assign recall_b1 = cmd_valid_in && (cmd_in == bmrm_pkg::BMRM_CMD_RECALL) && cmd_block_in;
  assign copy_go = cmd_valid_in && (cmd_in == bmrm_pkg::BMRM_CMD_COPY) && !block_locked[cmd_block_in];
  assign wake    = (mode == bmrm_pkg::BMRM_SLEEP) && (!switch_level || (status_bits[`BMRM_STATUS_SLEEP_BIT] && data_level));

  // ----------------------------------------
  // Power mode
  // ----------------------------------------
  // Data-low timer saturates so the long-low level stays until the line rises
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      low_count <= 32'h0;
      long_low  <= 1'b0;
    end
    else if (data_level)
    begin
      low_count <= 32'h0;
      long_low  <= 1'b0;
    end
    else if (low_count >= DATA_LOW_CYCLES)
      long_low <= 1'b1;
    else
      low_count <= low_count + 32'h1;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      mode <= bmrm_pkg::BMRM_ACTIVE;
    else if (wake)
      mode <= bmrm_pkg::BMRM_ACTIVE;
    else if (under_voltage_in || (status_bits[`BMRM_STATUS_SLEEP_BIT] && long_low))
      mode <= bmrm_pkg::BMRM_SLEEP;
  end

  // ----------------------------------------
  // Protection register
  // ----------------------------------------
  logic [3:0] cond_now;
  assign cond_now = {over_voltage_in, under_voltage_in, charge_overcurrent_in, discharge_overcurrent_in};

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      prot_flags       <= 4'h0;
      charge_enable    <= `BMRM_ENABLE_RESET;
      discharge_enable <= `BMRM_ENABLE_RESET;
    end
    else
    begin
      // A new condition wins over a clearing write in the same cycle
      if (wr_strobe_in && addr_in == `BMRM_PROTECTION_CONTROL)
        prot_flags <= (prot_flags & wr_data_in[7:4]) | cond_now;
      else
        prot_flags <= prot_flags | cond_now;
      if (wake)
      begin
        charge_enable    <= 1'b1;
        discharge_enable <= 1'b1;
      end
      else if (recall_b1)
      begin
        charge_enable    <= nonvol[{1'b1, `BMRM_DEFAULT_PROT_INDEX}][`BMRM_PROT_CHG_EN_BIT];
        discharge_enable <= nonvol[{1'b1, `BMRM_DEFAULT_PROT_INDEX}][`BMRM_PROT_DIS_EN_BIT];
      end
      else if (wr_strobe_in && addr_in == `BMRM_PROTECTION_CONTROL)
      begin
        charge_enable    <= wr_data_in[`BMRM_PROT_CHG_EN_BIT];
        discharge_enable <= wr_data_in[`BMRM_PROT_DIS_EN_BIT];
      end
    end
  end

  // Outputs registered so the mirror bits equal the pins exactly
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      charge_control_n_out    <= 1'b1;
      discharge_control_n_out <= 1'b1;
    end
    else
    begin
      charge_control_n_out    <= over_voltage_in | under_voltage_in | charge_overcurrent_in |
                                 !charge_enable | (mode == bmrm_pkg::BMRM_SLEEP);
      discharge_control_n_out <= under_voltage_in | charge_overcurrent_in | discharge_overcurrent_in |
                                 !discharge_enable | (mode == bmrm_pkg::BMRM_SLEEP);
    end
  end

  // ----------------------------------------
  // Status and nonvolatile control
  // ----------------------------------------
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      status_bits <= `BMRM_STATUS_RESET;
    else if (recall_b1)
      status_bits <= nonvol[{1'b1, `BMRM_DEFAULT_STAT_INDEX}] & `BMRM_STATUS_MASK;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      lock_enable  <= 1'b0;
      block_locked <= 2'b00;
      copy_count   <= 16'h0000;
    end
    else
    begin
      if (cmd_valid_in && cmd_in == bmrm_pkg::BMRM_CMD_LOCK && lock_enable)
      begin
        block_locked[cmd_block_in] <= 1'b1;
        lock_enable                <= 1'b0;
      end
      else if (wr_strobe_in && addr_in == `BMRM_NONVOLATILE_CONTROL)
        lock_enable <= wr_data_in[`BMRM_NVC_LOCK_EN_BIT];
      if (copy_go)
        copy_count <= `BMRM_COPY_CYCLES;
      else if (copy_count != 16'h0000)
        copy_count <= copy_count - 16'h0001;
    end
  end

  assign copy_busy_out = (copy_count != 16'h0000);

  // ----------------------------------------
  // Shadow, nonvolatile and SRAM arrays
  // ----------------------------------------
  // Nonvolatile contents survive reset on purpose
  always_ff @(posedge sys_clk_in)
  begin
    if (wr_nv)
      shadow[addr_in[4:0]] <= wr_data_in;
    else if (cmd_valid_in && cmd_in == bmrm_pkg::BMRM_CMD_RECALL)
      for (int i = 0; i < 16; i++)
        shadow[{cmd_block_in, 4'(i)}] <= nonvol[{cmd_block_in, 4'(i)}];
    if (copy_go)
      for (int j = 0; j < 16; j++)
        nonvol[{cmd_block_in, 4'(j)}] <= shadow[{cmd_block_in, 4'(j)}];
    if (wr_sram)
      sram[addr_in[3:0]] <= wr_data_in;
  end

  // ----------------------------------------
  // Special feature and general I/O
  // ----------------------------------------
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      switch_latch <= 1'b1;
      gpio_bit     <= 1'b1;
    end
    else
    begin
      if (!switch_level)
        switch_latch <= 1'b0;
      else if (wr_strobe_in && addr_in == `BMRM_SPECIAL_FEATURE && wr_data_in[`BMRM_SF_SWITCH_BIT])
        switch_latch <= 1'b1;
      if (mode == bmrm_pkg::BMRM_SLEEP || long_low)
        gpio_bit <= 1'b1;
      else if (wr_strobe_in && addr_in == `BMRM_SPECIAL_FEATURE)
        gpio_bit <= wr_data_in[`BMRM_SF_GPIO_BIT];
    end
  end

  assign general_io_pin_out    = 1'b0;
  assign general_io_pin_oe_out = !gpio_bit;
  assign sleep_out             = (mode == bmrm_pkg::BMRM_SLEEP);

  // ----------------------------------------
  // Measurement registers
  // ----------------------------------------
  // Sensor updates are dropped while a pair is held so the two bytes never tear
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      voltage_reg      <= 16'h0;
      current_reg      <= 16'h0;
      charge_total_reg <= 16'h0;
      temperature_reg  <= 16'h0;
      temp_count       <= 32'h0;
    end
    else
    begin
      temp_count <= (temp_count >= TEMP_CYCLES - 1) ? 32'h0 : temp_count + 32'h1;
      if (voltage_valid_in && !pair_held)
        voltage_reg <= voltage_in;
      if (current_valid_in && !pair_held)
        current_reg <= current_in;
      if (wr_strobe_in && addr_in == `BMRM_CHARGE_TOTAL_HIGH)
        charge_total_reg[15:8] <= wr_data_in;
      else if (wr_strobe_in && addr_in == `BMRM_CHARGE_TOTAL_LOW)
        charge_total_reg[7:0] <= wr_data_in;
      else if (charge_total_valid_in && !pair_held)
        charge_total_reg <= charge_total_in;
      if (temp_count >= TEMP_CYCLES - 1 && !pair_held)
        temperature_reg <= temperature_in;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic       is_high;
  logic [7:0] high_sel;
  logic [7:0] low_sel;

  always_comb
  begin
    is_high  = 1'b1;
    high_sel = 8'h00;
    low_sel  = 8'h00;
    case (addr_in)
      `BMRM_VOLTAGE_HIGH_BYTE: {high_sel, low_sel} = voltage_reg;
      `BMRM_CURRENT_HIGH_BYTE: {high_sel, low_sel} = current_reg;
      `BMRM_CHARGE_TOTAL_HIGH: {high_sel, low_sel} = charge_total_reg;
      `BMRM_TEMPERATURE_HIGH:  {high_sel, low_sel} = temperature_reg;
      default:                 is_high = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      pair_held   <= 1'b0;
      pair_low    <= 8'h00;
      rd_data_out <= 8'h00;
    end
    else
    begin
      if (rd_cmd_end_in)
        pair_held <= 1'b0;
      else if (rd_strobe_in && is_high)
      begin
        pair_held <= 1'b1;
        pair_low  <= low_sel;
      end
      if (rd_strobe_in)
      begin
        if (addr_in[7:5] == 3'h1)
          rd_data_out <= shadow[addr_in[4:0]];
        else if (addr_in[7:4] == `BMRM_SRAM_BASE)
          rd_data_out <= sram[addr_in[3:0]];
        else if (addr_in[7:5] != 3'h0)
          rd_data_out <= 8'h00;
        else if (is_high)
          rd_data_out <= high_sel;
        else
          case (addr_in)
            `BMRM_PROTECTION_CONTROL:
              rd_data_out <= {prot_flags, charge_control_n_out, discharge_control_n_out,
                              charge_enable, discharge_enable};
            `BMRM_DEVICE_STATUS:       rd_data_out <= status_bits;
            `BMRM_NONVOLATILE_CONTROL: rd_data_out <= {copy_busy_out, lock_enable, 4'h0, block_locked};
            `BMRM_SPECIAL_FEATURE:     rd_data_out <= {switch_latch, gpio_level, 6'h00};
            `BMRM_VOLTAGE_LOW_BYTE:    rd_data_out <= pair_held ? pair_low : voltage_reg[7:0];
            `BMRM_CURRENT_LOW_BYTE:    rd_data_out <= pair_held ? pair_low : current_reg[7:0];
            `BMRM_CHARGE_TOTAL_LOW:    rd_data_out <= pair_held ? pair_low : charge_total_reg[7:0];
            `BMRM_TEMPERATURE_LOW:     rd_data_out <= pair_held ? pair_low : temperature_reg[7:0];
            default:                   rd_data_out <= 8'h00;
          endcase
      end
    end
  end

endmodule

//--- bmrm_register_map_chk.sv
// Purpose: Port-level assertions for the register map
// Assumes: One clock, synchronous active-low reset
// Notes:   Outputs lag their cause by one register stage
module bmrm_register_map_chk
(
  // Clock and reset
  input wire logic       sys_clk_in,
  input wire logic       rst_n_in,
  // Observed ports
  input wire logic       rd_strobe_in,
  input wire logic       wr_strobe_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] rd_data_out,
  input wire logic       over_voltage_in,
  input wire logic       under_voltage_in,
  input wire logic       charge_overcurrent_in,
  input wire logic       discharge_overcurrent_in,
  input wire logic       general_io_pin_out,
  input wire logic       general_io_pin_oe_out,
  input wire logic       charge_control_n_out,
  input wire logic       discharge_control_n_out,
  input wire logic       sleep_out,
  input wire logic       copy_busy_out
);
  // ----------
  // Helpers
  // ----------
  logic [7:0] busy_cnt;
  logic       quiet;

  assign quiet = !(over_voltage_in || under_voltage_in || charge_overcurrent_in || discharge_overcurrent_in);

  // Copy time exceeds repetition limits, so it is counted
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in || !copy_busy_out)
      busy_cnt <= 8'h00;
    else
      busy_cnt <= busy_cnt + 8'h01;
  end

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  // ----------
  // Assertions
  // ----------
  a_io_drive_low: assert property ((general_io_pin_oe_out |-> !general_io_pin_out) and
    (wr_strobe_in && addr_in == 8'h08 && wr_data_in[6] |=> !general_io_pin_oe_out))
    else $error("io driver not low");
  a_sleep_io_off: assert property (sleep_out [*3] |-> !general_io_pin_oe_out)
    else $error("io driver on in sleep");
  a_sleep_fets_off: assert property (sleep_out [*2] |-> charge_control_n_out && discharge_control_n_out)
    else $error("fet on in sleep");
  a_over_chg_off: assert property (over_voltage_in [*2] |-> charge_control_n_out)
    else $error("charge on in overvoltage");
  a_oc_both_off: assert property ((charge_overcurrent_in || under_voltage_in) [*2] |->
    charge_control_n_out && discharge_control_n_out)
    else $error("fet on in fault");
  a_dis_oc_off: assert property (discharge_overcurrent_in [*2] |-> discharge_control_n_out)
    else $error("discharge on in overcurrent");
  a_copy_busy_len: assert property ($fell(copy_busy_out) |-> busy_cnt == 8'h10)
    else $error("copy busy length");
  a_copy_busy_max: assert property (copy_busy_out |-> busy_cnt < 8'h10)
    else $error("copy busy too long");
  a_reserved_zero: assert property (rd_strobe_in && (addr_in inside {[8'h40:8'h7f], [8'h90:8'hff]})
    |=> rd_data_out == 8'h00)
    else $error("reserved read not zero");
  a_mirror_pins: assert property (rd_strobe_in && addr_in == 8'h00 |=>
    rd_data_out[3:2] == {$past(charge_control_n_out), $past(discharge_control_n_out)})
    else $error("pin mirror wrong");
  a_wake_dis_on: assert property ($fell(sleep_out) && quiet |-> ##[0:2] !discharge_control_n_out)
    else $error("no discharge on wake");
endmodule

bind bmrm_register_map bmrm_register_map_chk i_chk (.*);

//--- bmrm_pin_model.sv
// Purpose: Pins and host line around the register map
// Assumes: Pull-ups on io pin, switch pin and data line
// Notes:   Any party pulling low wins
module bmrm_pin_model
(
  // Device drivers
  input  wire logic io_oe_in,
  input  wire logic io_drive_in,
  // Far side
  input  wire logic io_ext_low_in,
  input  wire logic switch_press_in,
  input  wire logic host_hold_low_in,
  // Pin levels
  output logic      io_level_out,
  output logic      switch_n_out,
  output logic      serial_data_out
);
  assign io_level_out    = !((io_oe_in && !io_drive_in) || io_ext_low_in);
  assign switch_n_out    = !switch_press_in;
  assign serial_data_out = !host_hold_low_in;
endmodule

//--- bmrm_register_map_bench.sv
// Purpose: Self-checking bench for the register map
// Assumes: Short sample and data-low counts
// Notes:   Pins resolve through the pin model
`define CHECK(g, e) \
  begin n_tests++; if ((g) !== (e)) \
  begin error_cnt++; $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end

module bmrm_register_map_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic                clk, rst_n, rd, wr, rd_end, cmd_v, cmd_blk, v_val, seen_busy;
  logic [7:0]          addr, wdata, rdata;
  logic [15:0]         volt, temp;
  bmrm_pkg::bmrm_cmd_e cmd;
  logic                ovr, unv, c_oc, d_oc, io_ext, press, hold_low;
  logic                io_lvl, sw_n, sdata, io_out, io_oe, chg_n, dis_n, sleep, busy;
  int                  error_cnt, n_tests;

  bmrm_register_map #(.TEMP_CYCLES(50), .DATA_LOW_CYCLES(100)) i_bmrm_register_map
  (
    .sys_clk_in(clk), .rst_n_in(rst_n), .rd_strobe_in(rd), .wr_strobe_in(wr), .rd_cmd_end_in(rd_end),
    .addr_in(addr), .wr_data_in(wdata), .rd_data_out(rdata), .cmd_valid_in(cmd_v), .cmd_in(cmd),
    .cmd_block_in(cmd_blk), .voltage_valid_in(v_val), .voltage_in(volt), .current_valid_in(v_val),
    .current_in(volt), .charge_total_valid_in(v_val), .charge_total_in(volt), .temperature_in(temp),
    .over_voltage_in(ovr), .under_voltage_in(unv), .charge_overcurrent_in(c_oc), .discharge_overcurrent_in(d_oc),
    .serial_data_in(sdata), .power_switch_n_in(sw_n), .general_io_pin_in(io_lvl), .general_io_pin_out(io_out),
    .general_io_pin_oe_out(io_oe), .charge_control_n_out(chg_n), .discharge_control_n_out(dis_n),
    .sleep_out(sleep), .copy_busy_out(busy)
  );

  bmrm_pin_model i_bmrm_pin_model
  (
    .io_oe_in(io_oe), .io_drive_in(io_out), .io_ext_low_in(io_ext), .switch_press_in(press),
    .host_hold_low_in(hold_low), .io_level_out(io_lvl), .switch_n_out(sw_n), .serial_data_out(sdata)
  );

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----------
  // Bus tasks
  // ----------
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task wr_b(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHECK(rdata, e)
  endtask

  task run_cmd(input bmrm_pkg::bmrm_cmd_e c, input logic b);
    @(posedge clk);
    cmd <= c;
    cmd_blk <= b;
    cmd_v <= 1'b1;
    @(posedge clk);
    cmd_v <= 1'b0;
    cyc(1);
    #1;
    seen_busy = busy;
    for (int i = 0; i < 40 && busy !== 1'b0; i++)
    begin
      @(posedge clk);
      #1;
    end
    `CHECK(busy, 1'b0)
  endtask

  task hold(input int n);
    @(posedge clk);
    hold_low <= 1'b1;
    cyc(n);
    hold_low <= 1'b0;
    #1;
  endtask

  // ----------
  // Scenarios
  // ----------
  task t_flags;
    logic [7:0] on_val [3];
    on_val = '{8'h8b, 8'h2f, 8'h17};
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk);
      {ovr, c_oc, d_oc} <= 3'b100 >> i;
      cyc(3);
      rdc(8'h00, on_val[i]);
      @(posedge clk);
      {ovr, c_oc, d_oc} <= 3'b000;
      wr_b(8'h00, 8'hff);
      rdc(8'h00, on_val[i] & 8'hf3);
      wr_b(8'h00, 8'h0f);
      rdc(8'h00, 8'h03);
    end
    $display("t_flags done");
  endtask

  task t_enables;
    wr_b(8'h00, 8'h00);
    rdc(8'h00, 8'h0c);
    wr_b(8'h00, 8'h02);
    rdc(8'h00, 8'h06);
    wr_b(8'h00, 8'h01);
    rdc(8'h00, 8'h09);
    wr_b(8'h00, 8'h03);
    $display("t_enables done");
  endtask

  task t_io;
    wr_b(8'h08, 8'h80);
    cyc(2);
    #1;
    `CHECK(io_oe, 1'b1)
    cyc(6);
    rdc(8'h08, 8'h80);
    wr_b(8'h08, 8'hc0);
    io_ext <= 1'b1;
    cyc(6);
    rdc(8'h08, 8'h80);
    io_ext <= 1'b0;
    cyc(6);
    rdc(8'h08, 8'hc0);
    $display("t_io done");
  endtask

  task t_switch;
    @(posedge clk);
    press <= 1'b1;
    cyc(8);
    press <= 1'b0;
    cyc(6);
    #1;
    `CHECK(sleep, 1'b0)
    rdc(8'h00, 8'h03);
    rdc(8'h08, 8'h40);
    wr_b(8'h08, 8'hc0);
    rdc(8'h08, 8'hc0);
    $display("t_switch done");
  endtask

  task t_uv_sleep;
    wr_b(8'h08, 8'h80);
    unv <= 1'b1;
    cyc(3);
    unv <= 1'b0;
    cyc(4);
    #1;
    `CHECK(sleep, 1'b1)
    `CHECK(io_oe, 1'b0)
    `CHECK({chg_n, dis_n}, 2'b11)
    rdc(8'h08, 8'hc0);
    wr_b(8'h00, 8'h00);
    press <= 1'b1;
    cyc(8);
    press <= 1'b0;
    cyc(6);
    #1;
    `CHECK(sleep, 1'b0)
    rdc(8'h00, 8'h03);
    wr_b(8'h08, 8'hc0);
    $display("t_uv_sleep done");
  endtask

  task t_nv;
    wr_b(8'h20, 8'ha5);
    rdc(8'h20, 8'ha5);
    run_cmd(bmrm_pkg::BMRM_CMD_COPY, 1'b0);
    `CHECK(seen_busy, 1'b1)
    wr_b(8'h20, 8'h5a);
    run_cmd(bmrm_pkg::BMRM_CMD_RECALL, 1'b0);
    rdc(8'h20, 8'ha5);
    wr_b(8'h07, 8'h40);
    run_cmd(bmrm_pkg::BMRM_CMD_LOCK, 1'b0);
    rdc(8'h07, 8'h01);
    wr_b(8'h20, 8'hff);
    rdc(8'h20, 8'ha5);
    run_cmd(bmrm_pkg::BMRM_CMD_COPY, 1'b0);
    `CHECK(seen_busy, 1'b0)
    run_cmd(bmrm_pkg::BMRM_CMD_RECALL, 1'b0);
    rdc(8'h20, 8'ha5);
    wr_b(8'h8f, 8'h3c);
    rdc(8'h8f, 8'h3c);
    wr_b(8'h40, 8'h55);
    rdc(8'h40, 8'h00);
    $display("t_nv done");
  endtask

  task t_block1;
    wr_b(8'h08, 8'h80);
    hold(120);
    `CHECK(io_oe, 1'b0)
    `CHECK(sleep, 1'b0)
    wr_b(8'h30, 8'h02);
    wr_b(8'h31, 8'h20);
    run_cmd(bmrm_pkg::BMRM_CMD_COPY, 1'b1);
    run_cmd(bmrm_pkg::BMRM_CMD_RECALL, 1'b1);
    rdc(8'h01, 8'h20);
    rdc(8'h00, 8'h06);
    hold(120);
    `CHECK(sleep, 1'b1)
    cyc(8);
    #1;
    `CHECK(sleep, 1'b0)
    rdc(8'h00, 8'h03);
    $display("t_block1 done");
  endtask

  task t_pair;
    @(posedge clk);
    v_val <= 1'b1;
    volt <= 16'h1234;
    temp <= 16'hfff6;
    @(posedge clk);
    v_val <= 1'b0;
    rdc(8'h0c, 8'h12);
    @(posedge clk);
    v_val <= 1'b1;
    volt <= 16'habcd;
    @(posedge clk);
    v_val <= 1'b0;
    rdc(8'h0d, 8'h34);
    @(posedge clk);
    rd_end <= 1'b1;
    @(posedge clk);
    rd_end <= 1'b0;
    v_val <= 1'b1;
    @(posedge clk);
    v_val <= 1'b0;
    rdc(8'h0d, 8'hcd);
    cyc(60);
    rdc(8'h18, 8'hff);
    rdc(8'h19, 8'hf6);
    rdc(8'h0e, 8'hab);
    rdc(8'h0f, 8'hcd);
    $display("t_pair done");
  endtask

  task give_verdict;
    $display("checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    cyc(20000);
    error_cnt++;
    $display("watchdog expired");
    give_verdict;
  end

  initial
  begin
    {rst_n, rd, wr, rd_end, cmd_v, cmd_blk, v_val, ovr, unv, c_oc, d_oc, io_ext, press, hold_low} = '0;
    {addr, wdata, volt, temp} = '0;
    cmd = bmrm_pkg::BMRM_CMD_NONE;
    cyc(20);
    rst_n <= 1'b1;
    rdc(8'h00, 8'h03);
    rdc(8'h08, 8'hc0);
    rdc(8'h05, 8'h00);
    t_flags;
    t_enables;
    t_io;
    t_switch;
    t_uv_sleep;
    t_nv;
    t_block1;
    t_pair;
    give_verdict;
  end
endmodule
